// [fwss_array.sv]
// Purpose: word array of both banks with one read and one write port
// Assumes: write port driven by the sequencer only
// Notes:   reset fills the array with erased words to give a known start
module fwss_array (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire fwss_pkg::fwss_mwr_s    wr,
	input  wire logic [fwss_pkg::FWSS_IDXW-1:0] rd_idx,
	output logic [31:0]                 rd_data
);
	import fwss_pkg::*;

	logic [31:0] mem_q [FWSS_WORDS];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < FWSS_WORDS; i++) begin
				mem_q[i] <= FWSS_ERASED;
			end
		end else if (wr.we) begin
			if (wr.erase) begin
				mem_q[wr.idx] <= FWSS_ERASED;
			end else begin
				mem_q[wr.idx] <= mem_q[wr.idx] & wr.data;
			end
		end
	end

	assign rd_data = mem_q[rd_idx];
endmodule : fwss_array

// [fwss_cpu.sv]
// Purpose: software side of the sequencer, as a classic Wishbone master
// Assumes: one request at a time, released after ack is sampled or after 20 cycles without one
// Notes:   hung rises when an ack or a completion never comes
module fwss_cpu
	import fwss_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] rdat,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [3:0]       sel,
	output logic [20:0]      adr,
	output logic [31:0]      wdat,
	output logic             hung
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{cyc, stb, we, sel, adr, wdat, hung} = '0;
	end
	// ==========================================================
	// bus cycles
	task automatic acc(input logic w, input logic [20:0] a, input logic [31:0] d, output logic [31:0] q);
		logic got;
		got = 1'b0;
		@(posedge clk);
		{cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hF, a, d};
		for (int i = 0; i < 20 && !got; i++) begin
			@(posedge clk);
			got = ack;
		end
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (!got) begin
			hung <= 1'b1;
		end
	endtask : acc
	task automatic wr(input logic [20:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [20:0] a, output logic [31:0] q);
		acc(1'b0, a, 32'h0, q);
	endtask : rd
	// ==========================================================
	// operation sequences, interrupt enable always set
	task automatic launch(input logic [31:0] op, input logic [20:0] a, input logic [31:0] d0,
			input logic [31:0] d1, input logic [31:0] sec);
		wr(FWSS_CR0_ADR, op | 32'h00200000);
		wr(FWSS_CR1_ADR, sec);
		wr(FWSS_AR_ADR, {11'h0, a});
		wr(FWSS_DR0_ADR, d0);
		wr(FWSS_DR1_ADR, d1);
		wr(FWSS_CR0_ADR, op | 32'h80200000);
	endtask : launch
	task automatic resume(input logic [31:0] op);
		wr(FWSS_CR0_ADR, op | 32'h00200000);
		wr(FWSS_CR0_ADR, op | 32'h80200000);
	endtask : resume
	// status only from registers, never from a bank under write
	task automatic poll(output logic [31:0] er);
		logic [31:0] q;
		q = 32'h80000000;
		for (int i = 0; i < 400 && q[31] !== 1'b0; i++) begin
			rd(FWSS_CR0_ADR, q);
		end
		if (q[31] !== 1'b0) begin
			hung <= 1'b1;
		end
		rd(FWSS_ER_ADR, er);
	endtask : poll
endmodule : fwss_cpu

// [fwss_delay.sv]
// Purpose: microsecond delay counter for program, erase and set-up phases
// Assumes: len is at least one
// Notes:   abort drops a running count without a done pulse
module fwss_delay (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      start,
	input  wire logic                      abort,
	input  wire logic [fwss_pkg::FWSS_TW-1:0] len,
	output logic                           done
);
	import fwss_pkg::*;

	localparam int DW = $clog2(FWSS_TICK_CYC);

	logic [DW-1:0]      div_q;
	logic               tick;
	logic [FWSS_TW-1:0] cnt_q;
	logic               run_q;

	assign tick = (div_q == DW'(FWSS_TICK_CYC - 1));

	// ==========================================================
	// one microsecond enable
	always_ff @(posedge clk) begin
		if (!rst_n || start) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + DW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= len;
				run_q <= 1'b1;
			end else if (abort) begin
				run_q <= 1'b0;
			end else if (run_q && tick) begin
				if (cnt_q <= FWSS_TW'(1)) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end else begin
					cnt_q <= cnt_q - FWSS_TW'(1);
				end
			end
		end
	end
endmodule : fwss_delay

// [fwss_pkg.sv]
// Purpose: shared constants and types of the flash write/suspend sequencer
// Assumes: 20 MHz system clock, 32-bit classic Wishbone register bus
// Notes:   array geometry is scaled down, every sector holds the same word count
package fwss_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [20:0] FWSS_CR0_ADR  = 21'h100000;
	localparam logic [20:0] FWSS_CR1_ADR  = 21'h100004;
	localparam logic [20:0] FWSS_DR0_ADR  = 21'h100008;
	localparam logic [20:0] FWSS_DR1_ADR  = 21'h10000C;
	localparam logic [20:0] FWSS_AR_ADR   = 21'h100010;
	localparam logic [20:0] FWSS_ER_ADR   = 21'h100014;
	localparam int          FWSS_REG_BIT  = 20;
	localparam int          FWSS_BANK_LSB = 18;
	localparam logic [1:0]  FWSS_B1_TAG   = 2'h3;
	localparam int          FWSS_WB       = 2;
	// ==========================================================
	// field positions
	localparam int FWSS_START_BIT = 31;
	localparam int FWSS_HOLD_BIT  = 30;
	localparam int FWSS_WORD_SEL  = 29;
	localparam int FWSS_DWORD_SEL = 28;
	localparam int FWSS_ERASE_SEL = 27;
	localparam int FWSS_IRQ_EN    = 21;
	localparam int FWSS_INTP = 20;
	localparam int FWSS_LOCK = 4;
	localparam int FWSS_BSY1 = 2;
	localparam int FWSS_BSY0 = 1;
	localparam int FWSS_CR1_B1 = 16;
	localparam int FWSS_ER_ERR = 0;
	localparam int FWSS_ER_SEQ = 1;
	localparam int FWSS_ER_RES = 2;
	localparam logic [31:0] FWSS_REG_RST  = 32'h00000000;
	localparam logic [31:0] FWSS_ERASED   = 32'hFFFFFFFF;
	localparam logic [31:0] FWSS_BAD_DATA = 32'h0BAD0BAD;
	// ==========================================================
	// array geometry
	localparam int FWSS_NS0   = 8;
	localparam int FWSS_NS1   = 2;
	localparam int FWSS_NS    = FWSS_NS0 + FWSS_NS1;
	localparam int FWSS_S0B   = $clog2(FWSS_NS0);
	localparam int FWSS_SB    = $clog2(FWSS_NS);
	localparam int FWSS_OB    = 4;
	localparam int FWSS_IDXW  = FWSS_SB + FWSS_OB;
	localparam int FWSS_WORDS = FWSS_NS << FWSS_OB;
	// ==========================================================
	// timing
	localparam int FWSS_CLK_MHZ  = 20;
	localparam int FWSS_TICK_NS  = 1000;
	localparam int FWSS_TICK_CYC = (FWSS_TICK_NS * FWSS_CLK_MHZ + 999) / 1000;
	localparam int FWSS_TW       = 16;
	localparam int FWSS_PROG_US  = 20;
	localparam int FWSS_ERASE_US = 1000;
	localparam int FWSS_INIT_US  = 200;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		OP_NONE  = 2'b00,
		OP_WORD  = 2'b01,
		OP_DWORD = 2'b10,
		OP_ERASE = 2'b11
	} fwss_op_e;
	typedef enum logic [2:0] {
		SQ_IDLE  = 3'b000,
		SQ_CHECK = 3'b001,
		SQ_INIT  = 3'b010,
		SQ_WAIT  = 3'b011,
		SQ_WRITE = 3'b100
	} fwss_state_e;
	typedef struct packed {
		logic                 we;
		logic                 erase;
		logic [FWSS_IDXW-1:0] idx;
		logic [31:0]          data;
	} fwss_mwr_s;

	function automatic logic [FWSS_IDXW-1:0] fwss_idx(input logic [20:0] a);
		logic [FWSS_SB-1:0] gs;
		gs = '0;
		if (a[FWSS_BANK_LSB +: 2] == FWSS_B1_TAG) begin
			gs = FWSS_SB'(FWSS_NS0) + FWSS_SB'(a[FWSS_WB + FWSS_OB]);
		end else begin
			gs = FWSS_SB'(a[FWSS_WB + FWSS_OB +: FWSS_S0B]);
		end
		return {gs, a[FWSS_WB +: FWSS_OB]};
	endfunction : fwss_idx
endpackage : fwss_pkg

// [fwss_top.sv]
// Purpose: flash program/erase sequencer with suspend, behind classic Wishbone
// Assumes: one clock, synchronous active-low reset, software polls the status bits
// Notes:   flash space when address bit 20 is low, control registers when high
module fwss_top #(
	parameter int ERASE_US = fwss_pkg::FWSS_ERASE_US,
	parameter int INIT_US  = fwss_pkg::FWSS_INIT_US
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [20:0] WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             FLASH_IRQ
);
	import fwss_pkg::*;

	// ==========================================================
	// state
	logic        start_q;
	logic        hold_q;
	logic [2:0]  sel_q;
	logic        irq_en_q;
	logic        intp_q;
	logic [31:0] cr1_q;
	logic [31:0] dr0_q;
	logic [31:0] dr1_q;
	logic [20:0] ar_q;
	logic        err_q;
	logic        seq_err_q;
	logic        reser_q;
	fwss_state_e state_q;
	fwss_op_e    op_q;
	fwss_op_e    held_op_q;
	logic [1:0]  busy_q;
	logic        lock_q;
	logic [FWSS_IDXW-1:0] ptr_q;
	logic        dw_hi_q;
	logic        init_done_q;
	logic        nohold_q;

	// ==========================================================
	// combinational
	logic        req;
	logic        wr;
	logic        is_reg;
	logic [20:0] adr_w;
	logic        wr_cr0;
	logic        wr_cr1;
	logic        wr_dr0;
	logic        wr_dr1;
	logic        wr_ar;
	logic        wr_er;
	logic [31:0] cr0_rd;
	logic [31:0] cr0_w;
	logic [2:0]  wsel;
	logic        multi;
	logic        start_req;
	fwss_op_e    start_op;
	logic [FWSS_NS-1:0]   ssel;
	logic [FWSS_IDXW-1:0] ar_idx;
	logic        chk_seq;
	logic        chk_res;
	logic        chk_fail;
	logic        resume;
	logic [1:0]  op_mask;
	logic        hold_take;
	logic        op_end;
	logic        seq_end;
	logic        t_start;
	logic        t_done;
	logic [FWSS_TW-1:0] t_len;
	fwss_mwr_s   mwr;
	logic [31:0] arr_rd;
	logic [31:0] rd_val;
	logic        rd_bank;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// ==========================================================
	// bus decode
	assign req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr     = req && WB_WE_I;
	assign is_reg = WB_ADR_I[FWSS_REG_BIT];
	assign adr_w  = {WB_ADR_I[20:FWSS_WB], 2'b00};
	assign wr_cr0 = wr && is_reg && (adr_w == FWSS_CR0_ADR);
	assign wr_cr1 = wr && is_reg && (adr_w == FWSS_CR1_ADR);
	assign wr_dr0 = wr && is_reg && (adr_w == FWSS_DR0_ADR);
	assign wr_dr1 = wr && is_reg && (adr_w == FWSS_DR1_ADR);
	assign wr_ar  = wr && is_reg && (adr_w == FWSS_AR_ADR);
	assign wr_er  = wr && is_reg && (adr_w == FWSS_ER_ADR);

	always_comb begin
		cr0_rd            = FWSS_REG_RST;
		cr0_rd[FWSS_START_BIT] = start_q;
		cr0_rd[FWSS_HOLD_BIT]  = hold_q;
		cr0_rd[FWSS_WORD_SEL]  = sel_q[2];
		cr0_rd[FWSS_DWORD_SEL] = sel_q[1];
		cr0_rd[FWSS_ERASE_SEL] = sel_q[0];
		cr0_rd[FWSS_IRQ_EN]    = irq_en_q;
		cr0_rd[FWSS_INTP] = intp_q;
		cr0_rd[FWSS_LOCK] = lock_q;
		cr0_rd[FWSS_BSY1] = busy_q[1];
		cr0_rd[FWSS_BSY0] = busy_q[0];
	end

	assign cr0_w = merge(cr0_rd, WB_DAT_I, WB_SEL_I);
	assign wsel  = {cr0_w[FWSS_WORD_SEL], cr0_w[FWSS_DWORD_SEL], cr0_w[FWSS_ERASE_SEL]};
	assign multi = (wsel & (wsel - 3'h1)) != 3'h0;

	always_comb begin
		unique case (wsel)
			3'b100:  start_op = OP_WORD;
			3'b010:  start_op = OP_DWORD;
			3'b001:  start_op = OP_ERASE;
			default: start_op = OP_NONE;
		endcase
	end

	// only one op at a time: starts are taken in idle only
	assign start_req = wr_cr0 && cr0_w[FWSS_START_BIT] && !start_q && (state_q == SQ_IDLE)
		&& !err_q && !cr0_w[FWSS_HOLD_BIT] && !multi && (start_op != OP_NONE);

	// ==========================================================
	// validation
	assign ssel    = {cr1_q[FWSS_CR1_B1 +: FWSS_NS1], cr1_q[FWSS_NS0-1:0]};
	assign ar_idx  = fwss_idx(ar_q);
	assign resume  = (op_q == held_op_q);
	assign chk_seq = ((op_q == OP_DWORD) && ar_q[FWSS_WB])
		|| ((op_q == OP_ERASE) && (ssel == '0))
		|| ((held_op_q == OP_ERASE) && (op_q != OP_ERASE) && ssel[ar_idx[FWSS_IDXW-1:FWSS_OB]]);
	assign chk_res = (held_op_q != OP_NONE) && (held_op_q != OP_ERASE) && !resume;
	assign chk_fail = chk_seq || chk_res;

	always_comb begin
		if (op_q == OP_ERASE) begin
			op_mask = {|ssel[FWSS_NS-1:FWSS_NS0], |ssel[FWSS_NS0-1:0]};
		end else if (ar_q[FWSS_BANK_LSB +: 2] == FWSS_B1_TAG) begin
			op_mask = 2'b10;
		end else begin
			op_mask = 2'b01;
		end
	end

	// ==========================================================
	// sequence control terms
	assign hold_take = hold_q && !nohold_q
		&& ((state_q == SQ_WAIT) || ((state_q == SQ_WRITE) && (op_q == OP_ERASE)));
	assign op_end = (state_q == SQ_WRITE) && !hold_take
		&& ((op_q == OP_ERASE) ? (ptr_q == FWSS_IDXW'(FWSS_WORDS - 1)) : (op_q == OP_WORD || dw_hi_q));
	assign seq_end = op_end || ((state_q == SQ_CHECK) && chk_fail);
	assign t_start = ((state_q == SQ_CHECK) && !chk_fail) || ((state_q == SQ_INIT) && t_done);

	always_comb begin
		if ((state_q == SQ_CHECK) && !init_done_q) begin
			t_len = FWSS_TW'(INIT_US);
		end else if (op_q == OP_ERASE) begin
			t_len = FWSS_TW'(ERASE_US);
		end else begin
			t_len = FWSS_TW'(FWSS_PROG_US);
		end
	end

	fwss_delay u_delay (
		.clk   (SYS_CLK),
		.rst_n (RESET_N),
		.start (t_start),
		.abort (hold_take),
		.len   (t_len),
		.done  (t_done)
	);

	// ==========================================================
	// array write port
	always_comb begin
		mwr       = '0;
		mwr.erase = (op_q == OP_ERASE);
		if (op_q == OP_ERASE) begin
			mwr.we   = (state_q == SQ_WRITE) && !hold_take && ssel[ptr_q[FWSS_IDXW-1:FWSS_OB]];
			mwr.idx  = ptr_q;
			mwr.data = FWSS_ERASED;
		end else begin
			mwr.we   = (state_q == SQ_WRITE);
			mwr.idx  = {ar_idx[FWSS_IDXW-1:1], ar_idx[0] | dw_hi_q};
			mwr.data = dw_hi_q ? dr1_q : dr0_q;
		end
	end

	fwss_array u_array (
		.clk     (SYS_CLK),
		.rst_n   (RESET_N),
		.wr      (mwr),
		.rd_idx  (fwss_idx(WB_ADR_I)),
		.rd_data (arr_rd)
	);

	// ==========================================================
	// sequencer
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			state_q     <= SQ_IDLE;
			op_q        <= OP_NONE;
			held_op_q   <= OP_NONE;
			busy_q      <= 2'b00;
			lock_q      <= 1'b0;
			ptr_q       <= '0;
			dw_hi_q     <= 1'b0;
			init_done_q <= 1'b0;
			nohold_q    <= 1'b0;
		end else begin
			unique case (state_q)
				SQ_IDLE: begin
					if (start_req) begin
						state_q <= SQ_CHECK;
						op_q    <= start_op;
						lock_q  <= 1'b1;
					end
				end
				SQ_CHECK: begin
					if (chk_fail) begin
						state_q <= SQ_IDLE;
						lock_q  <= 1'b0;
					end else begin
						busy_q   <= init_done_q ? op_mask : (op_mask | 2'b01);
						nohold_q <= (held_op_q == OP_ERASE) && (op_q != OP_ERASE);
						dw_hi_q  <= 1'b0;
						if (resume) begin
							held_op_q <= OP_NONE;
						end else if (op_q == OP_ERASE) begin
							ptr_q <= '0;
						end
						state_q <= init_done_q ? SQ_WAIT : SQ_INIT;
					end
				end
				SQ_INIT: begin
					if (t_done) begin
						init_done_q <= 1'b1;
						busy_q      <= op_mask;
						state_q     <= SQ_WAIT;
					end
				end
				SQ_WAIT: begin
					if (t_done && !hold_take) begin
						state_q <= SQ_WRITE;
					end
				end
				SQ_WRITE: begin
					if (op_q == OP_ERASE && !hold_take) begin
						ptr_q <= ptr_q + FWSS_IDXW'(1);
					end
					if (op_q == OP_DWORD) begin
						dw_hi_q <= 1'b1;
					end
				end
				default: begin
					state_q <= SQ_IDLE;
				end
			endcase
			if (hold_take) begin
				state_q   <= SQ_IDLE;
				busy_q    <= 2'b00;
				lock_q    <= 1'b0;
				held_op_q <= op_q;
			end
			if (op_end) begin
				state_q  <= SQ_IDLE;
				busy_q   <= 2'b00;
				lock_q   <= 1'b0;
				nohold_q <= 1'b0;
				if (op_q == OP_ERASE) begin
					ptr_q <= '0;
				end
			end
		end
	end

	// ==========================================================
	// control register 0
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			start_q   <= 1'b0;
			hold_q    <= 1'b0;
			sel_q     <= 3'b000;
			irq_en_q  <= 1'b0;
			intp_q    <= 1'b0;
			FLASH_IRQ <= 1'b0;
		end else begin
			if (wr_cr0) begin
				hold_q   <= cr0_w[FWSS_HOLD_BIT];
				irq_en_q <= cr0_w[FWSS_IRQ_EN];
				sel_q    <= multi ? 3'b000 : wsel;
				if (!cr0_w[FWSS_INTP]) begin
					intp_q <= 1'b0;
				end
			end
			if (start_req) begin
				start_q <= 1'b1;
			end
			if (seq_end || hold_take) begin
				start_q <= 1'b0;
			end
			if (seq_end) begin
				sel_q  <= 3'b000;
				intp_q <= 1'b1;
			end
			FLASH_IRQ <= irq_en_q && intp_q;
		end
	end

	// ==========================================================
	// operands, frozen while an operation holds the lock
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			cr1_q <= FWSS_REG_RST;
			dr0_q <= FWSS_REG_RST;
			dr1_q <= FWSS_REG_RST;
			ar_q  <= '0;
		end else if (!lock_q) begin
			if (wr_cr1) begin
				cr1_q <= merge(cr1_q, WB_DAT_I, WB_SEL_I) & {{(32-FWSS_CR1_B1-FWSS_NS1){1'b0}},
					{FWSS_NS1{1'b1}}, {(FWSS_CR1_B1-FWSS_NS0){1'b0}}, {FWSS_NS0{1'b1}}};
			end
			if (wr_dr0) begin
				dr0_q <= merge(dr0_q, WB_DAT_I, WB_SEL_I);
			end
			if (wr_dr1) begin
				dr1_q <= merge(dr1_q, WB_DAT_I, WB_SEL_I);
			end
			if (wr_ar) begin
				ar_q <= 21'(merge(32'(ar_q), WB_DAT_I, WB_SEL_I));
			end
		end
	end

	// ==========================================================
	// error register: a written zero clears, a new error wins
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			err_q   <= 1'b0;
			seq_err_q <= 1'b0;
			reser_q <= 1'b0;
		end else begin
			if (wr_er) begin
				err_q     <= err_q & WB_DAT_I[FWSS_ER_ERR];
				seq_err_q <= seq_err_q & WB_DAT_I[FWSS_ER_SEQ];
				reser_q   <= reser_q & WB_DAT_I[FWSS_ER_RES];
			end
			if ((state_q == SQ_CHECK) && chk_fail) begin
				err_q <= 1'b1;
				if (chk_seq) begin
					seq_err_q <= 1'b1;
				end
				if (chk_res) begin
					reser_q <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// read data and acknowledge
	assign rd_bank = (WB_ADR_I[FWSS_BANK_LSB +: 2] == FWSS_B1_TAG);

	always_comb begin
		rd_val = FWSS_REG_RST;
		if (!is_reg) begin
			rd_val = busy_q[rd_bank] ? FWSS_BAD_DATA : arr_rd;
		end else begin
			unique case (adr_w)
				FWSS_CR0_ADR: rd_val = cr0_rd;
				FWSS_CR1_ADR: rd_val = cr1_q;
				FWSS_DR0_ADR: rd_val = dr0_q;
				FWSS_DR1_ADR: rd_val = dr1_q;
				FWSS_AR_ADR:  rd_val = 32'(ar_q);
				FWSS_ER_ADR:  rd_val = {29'h0, reser_q, seq_err_q, err_q};
				default:      rd_val = FWSS_REG_RST;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= FWSS_REG_RST;
		end else begin
			WB_ACK_O <= req;
			if (req && !WB_WE_I) begin
				WB_DAT_O <= rd_val;
			end
		end
	end
endmodule : fwss_top

// [fwss_top_chk.sv]
// Purpose: port-level checks of the flash sequencer
// Assumes: classic Wishbone master holds the address until it samples ack
// Notes:   the interrupt enable is mirrored from taken control writes
module fwss_top_chk
	import fwss_pkg::*;
#(
	parameter int ERASE_US = FWSS_ERASE_US,
	parameter int INIT_US  = FWSS_INIT_US
) (
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [20:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        FLASH_IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	logic take;
	logic rd_ack;
	logic cr0_rd;
	logic irq_en_q;
	assign take   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign rd_ack = WB_ACK_O & ~WB_WE_I;
	assign cr0_rd = rd_ack & (WB_ADR_I == FWSS_CR0_ADR);
	// ==========================================================
	// interrupt enable as last written
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			irq_en_q <= 1'b0;
		end else if (take && WB_WE_I && WB_ADR_I == FWSS_CR0_ADR && WB_SEL_I[2]) begin
			irq_en_q <= WB_DAT_I[21];
		end
	end
	// ==========================================================
	// properties
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	chk_ack_next: assert property (take |=> WB_ACK_O)
		else $error("no ack one cycle after a request");
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (WB_ACK_O |-> $past(take))
		else $error("ack without a request");
	chk_irq_enable: assert property (FLASH_IRQ |-> $past(irq_en_q))
		else $error("interrupt while disabled");
	chk_cr0_unused: assert property (cr0_rd |-> (WB_DAT_O & ~32'hF8300016) == 32'h0)
		else $error("control word shows unused bits");
	chk_cr1_unused: assert property (rd_ack && WB_ADR_I == FWSS_CR1_ADR |-> WB_DAT_O[31:18] == 14'h0)
		else $error("sector word shows unused bits");
	chk_err_unused: assert property (rd_ack && WB_ADR_I == FWSS_ER_ADR |-> WB_DAT_O[31:3] == 29'h0)
		else $error("error word shows unused bits");
	chk_busy_lock: assert property (cr0_rd && WB_DAT_O[2:1] != 2'h0 |-> WB_DAT_O[31] && WB_DAT_O[4])
		else $error("busy without start and lock");
	chk_unmapped_zero: assert property (rd_ack && WB_ADR_I > FWSS_ER_ADR |-> WB_DAT_O == 32'h0)
		else $error("unmapped register reads nonzero");
	cov_start: cover property (take && WB_WE_I && WB_ADR_I == FWSS_CR0_ADR && WB_DAT_I[31]);
	cov_irq: cover property ($rose(FLASH_IRQ));
	cov_bad: cover property (rd_ack && WB_DAT_O == FWSS_BAD_DATA);
endmodule : fwss_top_chk

bind fwss_top fwss_top_chk #(.ERASE_US(ERASE_US), .INIT_US(INIT_US)) u_chk (
	.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FLASH_IRQ(FLASH_IRQ)
);

// [test_fwss_top.sv]
// Purpose: directed register-level test of the flash sequencer
// Assumes: erase and set-up delays shortened to 3 and 2 microseconds
// Notes:   the cpu model issues every bus cycle, this module checks
module test_fwss_top;
	import fwss_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] HOLD  = 32'h40000000;
	localparam logic [31:0] SEL_W = 32'h20000000;
	localparam logic [31:0] SEL_D = 32'h10000000;
	localparam logic [31:0] SEL_E = 32'h08000000;
	localparam logic [31:0] STAT  = 32'h80000016;
	localparam logic [31:0] E1    = FWSS_ERASED;
	localparam logic [20:0] CR0   = FWSS_CR0_ADR;
	logic        sys_clk, reset_n, cyc, stb, we, ack, irq, hung;
	logic [3:0]  sel;
	logic [20:0] adr;
	logic [31:0] wdat, rdat, q;
	int          err_total;
	int          num_checks;

	fwss_top #(.ERASE_US(3), .INIT_US(2)) uut (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.FLASH_IRQ(irq)
	);
	fwss_cpu cpu (
		.clk(sys_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .sel(sel),
		.adr(adr), .wdat(wdat), .hung(hung)
	);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// checking and closing
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic expect_rd(input logic [20:0] a, input logic [31:0] exp);
		logic [31:0] v;
		cpu.rd(a, v);
		chk_word(v, exp);
	endtask : expect_rd
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	always @(posedge hung) begin
		err_total++;
		finish_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		err_total = 0;
		num_checks = 0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		expect_rd(CR0, FWSS_REG_RST);
		expect_rd(21'h000004, E1);
		expect_rd(21'h100018, 32'h0);
		cpu.launch(SEL_W, 21'h0C0004, 32'h12345678, 32'h0, 32'h0);
		expect_rd(CR0, 32'hA0200016);
		expect_rd(21'h000000, FWSS_BAD_DATA);
		expect_rd(21'h0C0000, FWSS_BAD_DATA);
		cpu.poll(q);
		chk_word(q, 32'h0);
		chk_word({31'h0, irq}, 32'h1);
		expect_rd(21'h0C0004, 32'h12345678);
		cpu.launch(SEL_D, 21'h000008, 32'hA1B2C3D4, 32'h5E6F7081, 32'h1);
		cpu.wr(CR0, SEL_E | 32'h80200000);
		cpu.poll(q);
		chk_word(q, 32'h0);
		expect_rd(21'h000008, 32'hA1B2C3D4);
		expect_rd(21'h00000C, 32'h5E6F7081);
		cpu.launch(SEL_D, 21'h000014, 32'h0, 32'h0, 32'h0);
		cpu.poll(q);
		chk_word(q, 32'h3);
		cpu.launch(SEL_W, 21'h000018, 32'h0, 32'h0, 32'h0);
		cpu.poll(q);
		expect_rd(21'h000018, E1);
		cpu.wr(FWSS_ER_ADR, 32'h0);
		cpu.launch(SEL_W | SEL_D, 21'h00001C, 32'h0, 32'h0, 32'h0);
		cpu.poll(q);
		expect_rd(21'h00001C, E1);
		cpu.rd(CR0, q);
		chk_word(q & 32'hF8000000, 32'h0);
		cpu.wr(CR0, SEL_W);
		cpu.wr(FWSS_AR_ADR, 32'h00000020);
		cpu.wr(FWSS_DR0_ADR, 32'h0);
		cpu.wr(CR0, 32'h0);
		cpu.wr(CR0, 32'h80000000);
		expect_rd(21'h000020, E1);
		cpu.launch(SEL_W, 21'h000040, 32'h0, 32'h0, 32'h0);
		cpu.poll(q);
		cpu.launch(SEL_E, 21'h0, 32'h0, 32'h0, 32'h2);
		cpu.wr(CR0, SEL_E | HOLD | 32'h00200000);
		cpu.rd(CR0, q);
		chk_word(q & STAT, 32'h0);
		expect_rd(FWSS_CR1_ADR, 32'h2);
		expect_rd(21'h000040, 32'h0);
		cpu.launch(SEL_W, 21'h000080, 32'hA5A5A5A5, 32'h0, 32'h2);
		cpu.poll(q);
		chk_word(q, 32'h0);
		expect_rd(21'h000080, 32'hA5A5A5A5);
		cpu.resume(SEL_E);
		cpu.poll(q);
		chk_word(q, 32'h0);
		expect_rd(21'h000040, E1);
		expect_rd(21'h00007C, E1);
		expect_rd(21'h000080, 32'hA5A5A5A5);
		cpu.launch(SEL_W, 21'h000088, 32'h0000FFFF, 32'h0, 32'h0);
		cpu.wr(CR0, SEL_W | HOLD | 32'h00200000);
		cpu.rd(CR0, q);
		chk_word(q & STAT, 32'h0);
		cpu.resume(SEL_W);
		cpu.poll(q);
		chk_word(q, 32'h0);
		expect_rd(21'h000088, 32'h0000FFFF);
		cpu.launch(SEL_W, 21'h000090, 32'h0, 32'h0, 32'h0);
		cpu.wr(CR0, SEL_W | HOLD | 32'h00200000);
		cpu.wr(FWSS_CR1_ADR, 32'h4);
		cpu.resume(SEL_E);
		cpu.poll(q);
		chk_word(q, 32'h5);
		expect_rd(21'h000080, 32'hA5A5A5A5);
		cpu.wr(FWSS_CR1_ADR, 32'hFFFFFFFF);
		expect_rd(FWSS_CR1_ADR, 32'h000300FF);
		finish_test();
	end
endmodule : test_fwss_top
